// ===== ltc_pkg.sv
// package: register map, field layouts and decode tables of the line config
`default_nettype none

package ltc_pkg;

	// ------------------------------------------------------------------
	// register indices, byte address is four times the index
	// ------------------------------------------------------------------
	localparam logic [7:0] LTC_IDX_ONHOOK = 8'h10;
	localparam logic [7:0] LTC_IDX_LINE_VOLT = 8'h1d;
	localparam logic [7:0] LTC_IDX_AC_TERM = 8'h1e;
	localparam logic [7:0] LTC_IDX_CTL5 = 8'h1f;

	// ------------------------------------------------------------------
	// reset values and writable bits
	// ------------------------------------------------------------------
	localparam logic [7:0] LTC_AC_TERM_RST = 8'h00;
	localparam logic [7:0] LTC_CTL5_RST = 8'h20;
	localparam logic [7:0] LTC_ONHOOK_RST = 8'h00;
	localparam logic [7:0] LTC_AC_TERM_WMASK = 8'h3f;
	localparam logic [7:0] LTC_CTL5_WMASK = 8'heb;
	localparam logic [7:0] LTC_ONHOOK_WMASK = 8'h07;

	// ------------------------------------------------------------------
	// decode tables
	// ------------------------------------------------------------------
	localparam logic [9:0] LTC_OFFHOOK_MS_00 = 10'h200;
	localparam logic [9:0] LTC_OFFHOOK_MS_01 = 10'h080;
	localparam logic [9:0] LTC_OFFHOOK_MS_10 = 10'h040;
	localparam logic [9:0] LTC_OFFHOOK_MS_11 = 10'h008;
	localparam logic [1:0] LTC_SQUELCH_FULL = 2'h3;
	localparam logic [7:0] LTC_LVS_FORCE_V = 8'h03;

	// ------------------------------------------------------------------
	// bus answers
	// ------------------------------------------------------------------
	localparam logic [1:0] LTC_RESP_OKAY = 2'h0;
	localparam logic [1:0] LTC_RESP_SLVERR = 2'h2;

	// ------------------------------------------------------------------
	// types
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		LTC_FS_0DBM = 2'b00,
		LTC_FS_3P2DBM = 2'b01,
		LTC_FS_6DBM = 2'b10
	} ltc_fs_e;

	typedef enum logic [1:0] {
		LTC_OHS_FAST = 2'b00,
		LTC_OHS_3MS = 2'b01,
		LTC_OHS_26MS = 2'b10,
		LTC_OHS_OTHER = 2'b11
	} ltc_ohs_e;

	typedef struct packed {
		logic [1:0] rsv_hi;
		logic spare;
		logic double_full_scale_en;
		logic [3:0] ac_impedance_sel;
	} ltc_ac_term_s;

	typedef struct packed {
		logic full_scale_en;
		logic [1:0] offhook_counter_len;
		logic rsv4;
		logic onhook_speed_b;
		logic rsv2;
		logic filter_pole_sel;
		logic line_volt_force_dis;
	} ltc_ctl5_s;

	typedef struct packed {
		logic [4:0] rsv;
		logic [1:0] squelch_sel;
		logic onhook_speed_a;
	} ltc_onhook_s;

	typedef struct packed {
		logic [3:0] ac_impedance_sel;
		ltc_fs_e fs_level;
		logic [9:0] offhook_ms;
		ltc_ohs_e onhook_speed;
		logic filter_pole_sel;
		logic line_volt_force_dis;
	} ltc_cfg_s;

endpackage

`default_nettype wire

// ===== ltc_line_decode.sv
// module: turns register contents into line-side settings
`timescale 1ns/10ps
`default_nettype none

module ltc_line_decode
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// register contents
	input wire ltc_pkg::ltc_ac_term_s ac_term,
	input wire ltc_pkg::ltc_ctl5_s ctl5,
	input wire ltc_pkg::ltc_onhook_s onhook,
	// line side
	input wire logic [7:0] line_volt_raw,
	output var ltc_pkg::ltc_cfg_s line_cfg,
	output var logic [7:0] line_voltage_status
);

	// ------------------------------------------------------------------
	// decode functions
	// ------------------------------------------------------------------
	function automatic logic [9:0] offhook_ms(input logic [1:0] len);
		case (len)
			2'b00: offhook_ms = ltc_pkg::LTC_OFFHOOK_MS_00;
			2'b01: offhook_ms = ltc_pkg::LTC_OFFHOOK_MS_01;
			2'b10: offhook_ms = ltc_pkg::LTC_OFFHOOK_MS_10;
			default: offhook_ms = ltc_pkg::LTC_OFFHOOK_MS_11;
		endcase
	endfunction

	// magnitude of a two's complement voltage; polarity lives in bit 7
	function automatic logic [7:0] volt_mag(input logic [7:0] v);
		volt_mag = v[7] ? 8'((~v) + 8'h01) : v;
	endfunction

	// ------------------------------------------------------------------
	// combinational settings
	// ------------------------------------------------------------------
	ltc_pkg::ltc_fs_e fs_d;
	ltc_pkg::ltc_ohs_e ohs_d;
	ltc_pkg::ltc_cfg_s cfg_d;
	wire logic lvs_low;
	wire logic [7:0] lvs_d;

	// double scale overrides standard scale when both are set
	assign fs_d = ac_term.double_full_scale_en ? ltc_pkg::LTC_FS_6DBM :
		ctl5.full_scale_en ? ltc_pkg::LTC_FS_3P2DBM :
		ltc_pkg::LTC_FS_0DBM;

	always_comb
	begin
		ohs_d = ltc_pkg::LTC_OHS_OTHER;
		if (onhook.onhook_speed_a
			&& onhook.squelch_sel == ltc_pkg::LTC_SQUELCH_FULL)
			ohs_d = ltc_pkg::LTC_OHS_26MS;
		else if (!onhook.onhook_speed_a && onhook.squelch_sel == 2'h0)
			ohs_d = ctl5.onhook_speed_b ? ltc_pkg::LTC_OHS_3MS :
				ltc_pkg::LTC_OHS_FAST;
	end

	always_comb
	begin
		cfg_d = '0;
		cfg_d.ac_impedance_sel = ac_term.ac_impedance_sel;
		cfg_d.fs_level = fs_d;
		cfg_d.offhook_ms = offhook_ms(ctl5.offhook_counter_len);
		cfg_d.onhook_speed = ohs_d;
		cfg_d.filter_pole_sel = ctl5.filter_pole_sel;
		cfg_d.line_volt_force_dis = ctl5.line_volt_force_dis;
	end

	// low readings are noise near zero volts; zero them unless disabled
	assign lvs_low = volt_mag(line_volt_raw) <= ltc_pkg::LTC_LVS_FORCE_V;
	assign lvs_d = (lvs_low && !ctl5.line_volt_force_dis) ? 8'h00 :
		line_volt_raw;

	// ------------------------------------------------------------------
	// output flops
	// ------------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			line_cfg <= '0;
			line_voltage_status <= 8'h00;
		end
		else
		begin
			line_cfg <= cfg_d;
			line_voltage_status <= lvs_d;
		end
	end

endmodule

`default_nettype wire

// ===== ltc_regs.sv
// module: axi4-lite register bank for the line termination configuration
`timescale 1ns/10ps
`default_nettype none

module ltc_regs
#(
	parameter int ADDR_W = 12
)
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi write address
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// axi write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi read address
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// axi read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// line side
	input wire logic [7:0] line_volt_raw,
	output var ltc_pkg::ltc_cfg_s line_cfg,
	output var logic [7:0] line_voltage_status
);

	// ------------------------------------------------------------------
	// address decode
	// ------------------------------------------------------------------
	function automatic logic hit(input logic [ADDR_W-1:0] a,
		input logic [7:0] idx);
		hit = (a[ADDR_W-1:2] == (ADDR_W-2)'(idx));
	endfunction

	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	ltc_pkg::ltc_ac_term_s ac_q;
	ltc_pkg::ltc_ctl5_s ctl5_q;
	ltc_pkg::ltc_onhook_s onhook_q;
	logic aw_hold_q;
	logic [ADDR_W-1:0] awaddr_q;
	logic w_hold_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;

	// ------------------------------------------------------------------
	// write channel
	// ------------------------------------------------------------------
	// address and data may arrive in either order; each is parked until
	// its partner shows, and neither is taken while a response waits
	wire logic aw_take;
	wire logic w_take;
	wire logic do_write;
	wire logic [ADDR_W-1:0] wr_addr;
	wire logic [31:0] wr_data;
	wire logic [3:0] wr_strb;
	wire logic wr_lane0;
	wire logic wr_ac;
	wire logic wr_ctl5;
	wire logic wr_onhook;
	wire logic wr_lvs;
	wire logic wr_mapped;

	assign s_axi_awready = !aw_hold_q && !bvalid_q;
	assign s_axi_wready = !w_hold_q && !bvalid_q;
	assign aw_take = s_axi_awvalid && s_axi_awready;
	assign w_take = s_axi_wvalid && s_axi_wready;
	assign do_write = (aw_hold_q || aw_take) && (w_hold_q || w_take);
	assign wr_addr = aw_hold_q ? awaddr_q : s_axi_awaddr;
	assign wr_data = w_hold_q ? wdata_q : s_axi_wdata;
	assign wr_strb = w_hold_q ? wstrb_q : s_axi_wstrb;
	assign wr_lane0 = do_write && wr_strb[0];
	assign wr_ac = wr_lane0 && hit(wr_addr, ltc_pkg::LTC_IDX_AC_TERM);
	assign wr_ctl5 = wr_lane0 && hit(wr_addr, ltc_pkg::LTC_IDX_CTL5);
	assign wr_onhook = wr_lane0 && hit(wr_addr, ltc_pkg::LTC_IDX_ONHOOK);
	// line voltage is read-only; a write there is accepted and dropped
	assign wr_lvs = hit(wr_addr, ltc_pkg::LTC_IDX_LINE_VOLT);
	assign wr_mapped = hit(wr_addr, ltc_pkg::LTC_IDX_AC_TERM) ||
		hit(wr_addr, ltc_pkg::LTC_IDX_CTL5) ||
		hit(wr_addr, ltc_pkg::LTC_IDX_ONHOOK) || wr_lvs;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_hold_q <= 1'b0;
			awaddr_q <= '0;
			w_hold_q <= 1'b0;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
			bvalid_q <= 1'b0;
			bresp_q <= ltc_pkg::LTC_RESP_OKAY;
		end
		else
		begin
			if (do_write)
			begin
				aw_hold_q <= 1'b0;
				w_hold_q <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q <= wr_mapped ? ltc_pkg::LTC_RESP_OKAY :
					ltc_pkg::LTC_RESP_SLVERR;
			end
			else
			begin
				if (aw_take)
				begin
					aw_hold_q <= 1'b1;
					awaddr_q <= s_axi_awaddr;
				end
				if (w_take)
				begin
					w_hold_q <= 1'b1;
					wdata_q <= s_axi_wdata;
					wstrb_q <= s_axi_wstrb;
				end
				if (s_axi_bready)
					bvalid_q <= 1'b0;
			end
		end
	end

	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;

	// ------------------------------------------------------------------
	// configuration registers
	// ------------------------------------------------------------------
	// masks keep reserved bits at zero so they read back as zero
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ac_q <= ltc_pkg::LTC_AC_TERM_RST;
			ctl5_q <= ltc_pkg::LTC_CTL5_RST;
			onhook_q <= ltc_pkg::LTC_ONHOOK_RST;
		end
		else
		begin
			if (wr_ac)
				ac_q <= wr_data[7:0] & ltc_pkg::LTC_AC_TERM_WMASK;
			if (wr_ctl5)
				ctl5_q <= wr_data[7:0] & ltc_pkg::LTC_CTL5_WMASK;
			if (wr_onhook)
				onhook_q <= wr_data[7:0] & ltc_pkg::LTC_ONHOOK_WMASK;
		end
	end

	// ------------------------------------------------------------------
	// read channel
	// ------------------------------------------------------------------
	wire logic ar_take;
	wire logic rd_mapped;
	logic [7:0] rd_byte;

	assign s_axi_arready = !rvalid_q;
	assign ar_take = s_axi_arvalid && s_axi_arready;
	assign rd_mapped = hit(s_axi_araddr, ltc_pkg::LTC_IDX_AC_TERM) ||
		hit(s_axi_araddr, ltc_pkg::LTC_IDX_CTL5) ||
		hit(s_axi_araddr, ltc_pkg::LTC_IDX_ONHOOK) ||
		hit(s_axi_araddr, ltc_pkg::LTC_IDX_LINE_VOLT);

	always_comb
	begin
		rd_byte = 8'h00;
		if (hit(s_axi_araddr, ltc_pkg::LTC_IDX_AC_TERM))
			rd_byte = ac_q;
		else if (hit(s_axi_araddr, ltc_pkg::LTC_IDX_CTL5))
			rd_byte = ctl5_q;
		else if (hit(s_axi_araddr, ltc_pkg::LTC_IDX_ONHOOK))
			rd_byte = onhook_q;
		else if (hit(s_axi_araddr, ltc_pkg::LTC_IDX_LINE_VOLT))
			rd_byte = line_voltage_status;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= ltc_pkg::LTC_RESP_OKAY;
		end
		else if (ar_take)
		begin
			rvalid_q <= 1'b1;
			rdata_q <= {24'h00_0000, rd_byte};
			rresp_q <= rd_mapped ? ltc_pkg::LTC_RESP_OKAY :
				ltc_pkg::LTC_RESP_SLVERR;
		end
		else if (s_axi_rready)
			rvalid_q <= 1'b0;
	end

	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;

	// ------------------------------------------------------------------
	// line-side decode
	// ------------------------------------------------------------------
	ltc_line_decode u_decode
	(
		.aclk(aclk),
		.aresetn(aresetn),
		.ac_term(ac_q),
		.ctl5(ctl5_q),
		.onhook(onhook_q),
		.line_volt_raw(line_volt_raw),
		.line_cfg(line_cfg),
		.line_voltage_status(line_voltage_status)
	);

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	chk_ac_rsv_zero: assert property (
		ac_q.rsv_hi == 2'h0 ##1 ac_q.rsv_hi == 2'h0)
		else $error("ac register reserved bits not zero");

	chk_spare_no_effect: assert property (
		(ac_q.spare != $past(ac_q.spare))
		&& (ac_q[4:0] == $past(ac_q[4:0])) && $stable(ctl5_q)
		|-> ##1 $stable(line_cfg.ac_impedance_sel)
		&& $stable(line_cfg.fs_level))
		else $error("spare bit changed line settings");

	chk_double_scale: assert property (
		wr_ac && wr_data[4] |-> ##2
		line_cfg.fs_level == ltc_pkg::LTC_FS_6DBM)
		else $error("double full scale not applied");

	chk_impedance_sel: assert property (
		wr_ac |-> ##2 line_cfg.ac_impedance_sel == $past(wr_data[3:0], 2))
		else $error("impedance select not applied");

	chk_std_scale: assert property (
		ctl5_q.full_scale_en && !ac_q.double_full_scale_en |=>
		line_cfg.fs_level == ltc_pkg::LTC_FS_3P2DBM)
		else $error("standard full scale not applied");

	chk_offhook_len: assert property (
		wr_ctl5 && wr_data[6:5] == 2'b00 |-> ##2
		line_cfg.offhook_ms == 10'h200)
		else $error("off-hook length wrong for code 00");

	chk_offhook_dflt: assert property (disable iff (1'b0)
		!aresetn ##1 aresetn |-> ctl5_q.offhook_counter_len == 2'b01)
		else $error("off-hook length default is not 128 ms");

	chk_onhook_spd: assert property (
		!onhook_q.onhook_speed_a && ctl5_q.onhook_speed_b
		&& onhook_q.squelch_sel == 2'h0 |=>
		line_cfg.onhook_speed == ltc_pkg::LTC_OHS_3MS)
		else $error("on-hook speed not 3 ms");

	chk_lvs_force: assert property (
		!ctl5_q.line_volt_force_dis && line_volt_raw == 8'hfd |=>
		line_voltage_status == 8'h00)
		else $error("low line voltage not forced to zero");

	chk_lvs_pass: assert property (
		ctl5_q.line_volt_force_dis |=>
		line_voltage_status == $past(line_volt_raw))
		else $error("line voltage forced while disabled");

	chk_write_resp: assert property (
		do_write |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready)
		else $error("write response missing one cycle after write");

	chk_read_resp: assert property (
		ar_take |=> s_axi_rvalid && s_axi_rdata[31:8] == 24'h00_0000)
		else $error("read data missing or upper bits not zero");

	cov_ac_write: cover property (wr_ac ##1 s_axi_bvalid);
	cov_lvs_read: cover property (
		ar_take && hit(s_axi_araddr, ltc_pkg::LTC_IDX_LINE_VOLT));
	cov_double_fs: cover property (
		line_cfg.fs_level == ltc_pkg::LTC_FS_6DBM);
	cov_onhook_26: cover property (
		line_cfg.onhook_speed == ltc_pkg::LTC_OHS_26MS);

endmodule

`default_nettype wire

// ===== ltc_line_model.sv
// line-side voltage source model feeding the raw line voltage sample
`timescale 1ns/10ps
`default_nettype none

module ltc_line_model
(
	// clock
	input wire logic aclk,
	// setpoint from the bench, volts in two's complement
	input wire logic [7:0] volts_set,
	// line side
	output logic [7:0] line_volt_raw
);
	// ------------------------------------------------------------------
	// converter sample
	// ------------------------------------------------------------------
	// the line side converts once per clock, so a new setpoint shows
	// one cycle late, just as a real sampler would
	always_ff @(posedge aclk)
	begin
		line_volt_raw <= volts_set;
	end
endmodule

`default_nettype wire

// ===== testbench.sv
// self-checking bench for the line termination config register bank
`timescale 1ns/10ps
`default_nettype none

module testbench;
	// ------------------------------------------------------------------
	// signals
	// ------------------------------------------------------------------
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [11:0] awaddr = 12'h000;
	logic awvalid = 1'b0;
	logic awready;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'h0;
	logic wvalid = 1'b0;
	logic wready;
	logic [1:0] bresp;
	logic bvalid;
	logic bready = 1'b0;
	logic [11:0] araddr = 12'h000;
	logic arvalid = 1'b0;
	logic arready;
	logic [31:0] rdata;
	logic [1:0] rresp;
	logic rvalid;
	logic rready = 1'b0;
	logic [7:0] volts_set = 8'h00;
	logic [7:0] line_volt_raw;
	ltc_pkg::ltc_cfg_s line_cfg;
	logic [7:0] line_voltage_status;
	int fails = 0;
	int total_checks = 0;
	logic [1:0] resp;
	logic [31:0] rd;
	logic [9:0] ms_tab [4] = '{10'h200, 10'h080, 10'h040, 10'h008};

	initial
	begin
		forever #2.5 aclk = ~aclk;
	end

	ltc_regs #(.ADDR_W(12)) uut
	(
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.line_volt_raw(line_volt_raw), .line_cfg(line_cfg),
		.line_voltage_status(line_voltage_status)
	);

	ltc_line_model u_line
	(
		.aclk(aclk), .volts_set(volts_set), .line_volt_raw(line_volt_raw)
	);

	// ------------------------------------------------------------------
	// checking and closing
	// ------------------------------------------------------------------
	task automatic final_report();
		if (fails == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic hang();
		fails++;
		$display("[FAIL] %0t handshake never answered", $time);
		final_report();
	endtask

	// ------------------------------------------------------------------
	// bus tasks
	// ------------------------------------------------------------------
	task automatic wr(input logic [11:0] a, input logic [31:0] d,
		input logic [3:0] s, output logic [1:0] r);
		bit aw_done;
		bit w_done;
		bit aw_ok;
		bit w_ok;
		bit b_ok;
		int n;
		aw_done = 0;
		w_done = 0;
		b_ok = 0;
		@(posedge aclk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wstrb <= s;
		wvalid <= 1'b1;
		bready <= 1'b1;
		// readies are looked at mid-cycle, where they are settled, so the
		// edge that follows is the one that takes the channel
		for (n = 0; n < 50 && !(aw_done && w_done); n++)
		begin
			@(negedge aclk);
			aw_ok = awready;
			w_ok = wready;
			@(posedge aclk);
			if (!aw_done && aw_ok)
			begin
				aw_done = 1;
				awvalid <= 1'b0;
			end
			if (!w_done && w_ok)
			begin
				w_done = 1;
				wvalid <= 1'b0;
			end
		end
		if (!(aw_done && w_done))
			hang();
		for (n = 0; n < 50 && !b_ok; n++)
		begin
			@(negedge aclk);
			b_ok = bvalid;
			r = bresp;
			@(posedge aclk);
		end
		if (!b_ok)
			hang();
		bready <= 1'b0;
	endtask

	task automatic rd_word(input logic [11:0] a, output logic [31:0] d,
		output logic [1:0] r);
		bit ar_ok;
		bit r_ok;
		int n;
		ar_ok = 0;
		r_ok = 0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 50 && !ar_ok; n++)
		begin
			@(negedge aclk);
			ar_ok = arready;
			@(posedge aclk);
		end
		if (!ar_ok)
			hang();
		arvalid <= 1'b0;
		for (n = 0; n < 50 && !r_ok; n++)
		begin
			@(negedge aclk);
			r_ok = rvalid;
			d = rdata;
			r = rresp;
			@(posedge aclk);
		end
		if (!r_ok)
			hang();
		rready <= 1'b0;
	endtask

	// write then let the decoded settings land
	task automatic wr_settle(input logic [11:0] a, input logic [7:0] d);
		logic [1:0] r;
		wr(a, {24'h0, d}, 4'hf, r);
		chk({30'h0, r}, 32'h0);
		repeat (3) @(posedge aclk);
	endtask

	task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
		logic [31:0] d;
		logic [1:0] r;
		rd_word(a, d, r);
		chk(d, exp);
		chk({30'h0, r}, 32'h0);
	endtask

	// ------------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------------
	initial
	begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		rd_chk(12'h078, 32'h00);
		rd_chk(12'h07c, 32'h20);
		chk({22'h0, line_cfg.offhook_ms}, 32'h080);
		chk({30'h0, line_cfg.fs_level}, 32'h0);
		// reserved top bits drop, the spare bit keeps its value
		wr_settle(12'h078, 8'hff);
		rd_chk(12'h078, 32'h3f);
		chk({30'h0, line_cfg.fs_level}, 32'h2);
		wr_settle(12'h078, 8'h20);
		rd_chk(12'h078, 32'h20);
		chk({28'h0, line_cfg.ac_impedance_sel}, 32'h0);
		for (int i = 0; i < 16; i++)
		begin
			wr_settle(12'h078, 8'(i));
			chk({28'h0, line_cfg.ac_impedance_sel}, 32'(i));
		end
		// full scale levels: standard alone, then both set
		wr_settle(12'h07c, 8'h80);
		chk({30'h0, line_cfg.fs_level}, 32'h1);
		wr_settle(12'h078, 8'h10);
		chk({30'h0, line_cfg.fs_level}, 32'h2);
		wr_settle(12'h078, 8'h00);
		for (int i = 0; i < 4; i++)
		begin
			wr_settle(12'h07c, 8'(i << 5));
			chk({22'h0, line_cfg.offhook_ms}, {22'h0, ms_tab[i]});
		end
		// every writable bit set, reserved bits written as zero
		wr_settle(12'h07c, 8'heb);
		rd_chk(12'h07c, 32'heb);
		chk({31'h0, line_cfg.filter_pole_sel}, 32'h1);
		// on-hook speed combinations through both speed bits and squelch
		wr_settle(12'h07c, 8'h20);
		wr_settle(12'h040, 8'h00);
		chk({30'h0, line_cfg.onhook_speed}, 32'h0);
		wr_settle(12'h07c, 8'h28);
		chk({30'h0, line_cfg.onhook_speed}, 32'h1);
		wr_settle(12'h040, 8'h07);
		chk({30'h0, line_cfg.onhook_speed}, 32'h2);
		wr_settle(12'h07c, 8'h20);
		chk({30'h0, line_cfg.onhook_speed}, 32'h2);
		wr_settle(12'h040, 8'h06);
		chk({30'h0, line_cfg.onhook_speed}, 32'h3);
		// low line voltage is zeroed unless force-disable is set
		volts_set <= 8'hfd;
		repeat (4) @(posedge aclk);
		chk({24'h0, line_voltage_status}, 32'h0);
		volts_set <= 8'h05;
		repeat (4) @(posedge aclk);
		chk({24'h0, line_voltage_status}, 32'h05);
		wr_settle(12'h07c, 8'h21);
		chk({31'h0, line_cfg.line_volt_force_dis}, 32'h1);
		volts_set <= 8'h02;
		repeat (4) @(posedge aclk);
		chk({24'h0, line_voltage_status}, 32'h02);
		rd_chk(12'h074, 32'h02);
		// strobe off leaves the register alone
		wr(12'h078, 32'h0a, 4'h0, resp);
		chk({30'h0, resp}, 32'h0);
		rd_chk(12'h078, 32'h00);
		// unmapped places answer with a slave error
		wr(12'h100, 32'h55, 4'hf, resp);
		chk({30'h0, resp}, 32'h2);
		rd_word(12'h100, rd, resp);
		chk(rd, 32'h0);
		chk({30'h0, resp}, 32'h2);
		final_report();
	end

	initial
	begin
		repeat (20000) @(posedge aclk);
		hang();
	end
endmodule

`default_nettype wire
